// [tone_generator.sv]
// Overview of operation
// - two independent resonant oscillators, one sample per 8 kHz tick
// - frequency coefficient is cos(2 pi f / fs) scaled by 2^14, plus amplitude, phase
// - amplitude coefficient scales output linearly, full scale 1.11 Vrms
// - fsk mode on generator 1 computes at 24 kHz using fsk coefficients
// - active and inactive timers; output only during active period
// - periods are 16-bit counts of 125 us ticks
// - both timer enables set make timers drive the oscillator enable
// - one 16-bit counter counts active, resets, then counts inactive, repeating
// - cadence runs until software clears the timer enables
// - zero-cross enable extends each burst to the next zero crossing
// - oscillator enable with only active timer gives one burst
// - both timer enables clear: output follows the enable bit
// - second generator identical with its own bits, except that it has no fsk mode
// - per-generator path select routes output to receive or transmit
// - active and inactive expiries raise interrupts, individually enabled
// - four timer status bits in the first interrupt vector register
module tone_generator
    import tone_pkg::*;
#(
    parameter int ADDR_W = 5
) (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic      [15:0]       reg_rdata,
    output logic                   irq,
    output logic signed [15:0]     rx_tone,
    output logic signed [15:0]     tx_tone,
    output logic                   sample_strobe
);
    import tone_pkg::*;

    logic [15:0] freq [2];
    logic [15:0] amp [2];
    logic [15:0] phase [2];
    logic [15:0] active_len [2];
    logic [15:0] inactive_len [2];
    logic [15:0] fsk_coef [4];
    logic [15:0] control;
    logic [1:0]  mode;
    logic [3:0]  irq_status;
    logic [3:0]  irq_mask;
    logic [15:0] tick_count;
    logic        tick;
    logic [3:0]  expire;
    logic [1:0]  run;
    logic        ctl_wr;

    assign ctl_wr = reg_write && reg_addr == REG_OSC_CONTROL;

    // sample tick; fsk on generator 1 runs three times faster
    // limitation: the 24 kHz rate only holds while generator 1 runs,
    // so generator 2 timers also step faster during an fsk burst
    logic [15:0] tick_max;
    assign tick_max = (control[CTL_OUT_EN] && mode[MODE_T1_FSK]) ? 16'(FSK_CYCLES - 1)
                                                                 : 16'(SAMPLE_CYCLES - 1);
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_count <= RESET_VALUE;
            tick       <= 1'b0;
        end else begin
            tick <= (tick_count >= tick_max);
            if (tick_count >= tick_max) begin
                tick_count <= RESET_VALUE;
            end else begin
                tick_count <= tick_count + 16'h0001;
            end
        end
    end
    assign sample_strobe = tick;

    // register writes
    // control and irq vector live in their own processes below
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 2; i++) begin
                freq[i]         <= RESET_VALUE;
                amp[i]          <= RESET_VALUE;
                phase[i]        <= RESET_VALUE;
                active_len[i]   <= RESET_VALUE;
                inactive_len[i] <= RESET_VALUE;
            end
            for (int i = 0; i < 4; i++) begin
                fsk_coef[i] <= RESET_VALUE;
            end
            mode     <= 2'h0;
            irq_mask <= 4'h0;
        end else if (reg_write) begin
            unique case (reg_addr)
                REG_T1_FREQ:     freq[0] <= reg_wdata;
                REG_T1_AMP:      amp[0] <= reg_wdata;
                REG_T1_PHASE:    phase[0] <= reg_wdata;
                REG_T1_ACTIVE:   active_len[0] <= reg_wdata;
                REG_T1_INACTIVE: inactive_len[0] <= reg_wdata;
                REG_T2_FREQ:     freq[1] <= reg_wdata;
                REG_T2_AMP:      amp[1] <= reg_wdata;
                REG_T2_PHASE:    phase[1] <= reg_wdata;
                REG_T2_ACTIVE:   active_len[1] <= reg_wdata;
                REG_T2_INACTIVE: inactive_len[1] <= reg_wdata;
                REG_OSC_MODE:    mode <= reg_wdata[1:0];
                REG_IRQ_ENABLE:  irq_mask <= reg_wdata[3:0];
                REG_FSK_SPACE_F: fsk_coef[0] <= reg_wdata;
                REG_FSK_MARK_F:  fsk_coef[1] <= reg_wdata;
                REG_FSK_SPACE_A: fsk_coef[2] <= reg_wdata;
                REG_FSK_MARK_A:  fsk_coef[3] <= reg_wdata;
                default: ;
            endcase
        end
    end

    // read port, data one cycle after the strobe
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= RESET_VALUE;
        end else if (reg_read) begin
            unique case (reg_addr)
                REG_T1_FREQ:     reg_rdata <= freq[0];
                REG_T1_AMP:      reg_rdata <= amp[0];
                REG_T1_PHASE:    reg_rdata <= phase[0];
                REG_T1_ACTIVE:   reg_rdata <= active_len[0];
                REG_T1_INACTIVE: reg_rdata <= inactive_len[0];
                REG_T2_FREQ:     reg_rdata <= freq[1];
                REG_T2_AMP:      reg_rdata <= amp[1];
                REG_T2_PHASE:    reg_rdata <= phase[1];
                REG_T2_ACTIVE:   reg_rdata <= active_len[1];
                REG_T2_INACTIVE: reg_rdata <= inactive_len[1];
                REG_OSC_CONTROL: reg_rdata <= control;
                REG_OSC_MODE:    reg_rdata <= {14'h0000, mode};
                REG_IRQ_VECTOR:  reg_rdata <= {12'h000, irq_status};
                REG_IRQ_ENABLE:  reg_rdata <= {12'h000, irq_mask};
                REG_FSK_SPACE_F: reg_rdata <= fsk_coef[0];
                REG_FSK_MARK_F:  reg_rdata <= fsk_coef[1];
                REG_FSK_SPACE_A: reg_rdata <= fsk_coef[2];
                REG_FSK_MARK_A:  reg_rdata <= fsk_coef[3];
                default:         reg_rdata <= RESET_VALUE;
            endcase
        end
    end

    logic [15:0] cad_count [2];
    logic [1:0]  in_active;
    logic [1:0]  ending;
    logic signed [17:0] y1 [2];
    logic signed [17:0] y2 [2];
    logic signed [15:0] tone_out [2];
    logic [1:0]  enable_q;

    for (genvar g = 0; g < 2; g++) begin : gen_tone
        logic ta_en;
        logic ti_en;
        logic zero_en;
        logic signed [15:0] coef_f;
        logic signed [15:0] coef_a;
        logic signed [33:0] prod;
        logic signed [17:0] next_y;
        logic               zc;

        assign ta_en   = control[8*g + CTL_TA_EN];
        assign ti_en   = control[8*g + CTL_TI_EN];
        assign zero_en = control[8*g + CTL_ZERO];
        assign run[g]  = control[8*g + CTL_OUT_EN];

        // fsk coefficients replace generator 1 coefficients
        assign coef_f = (g == 0 && mode[MODE_T1_FSK]) ? fsk_coef[mode[MODE_FSK_SS]] : freq[g];
        assign coef_a = (g == 0 && mode[MODE_T1_FSK]) ? fsk_coef[2 + 32'(mode[MODE_FSK_SS])]
                                                      : amp[g];

        // y[n] = 2*c*y[n-1] - y[n-2], c held as q14
        assign prod   = coef_f * y1[g];
        assign next_y = 18'(prod >>> (FREQ_SHIFT - 1)) - y2[g];
        assign zc     = (y1[g][17] != next_y[17]) || next_y == 18'sh00000;

        // restart from initial phase on enable
        always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
                y1[g]       <= 18'sh00000;
                y2[g]       <= 18'sh00000;
                enable_q[g] <= 1'b0;
            end else begin
                enable_q[g] <= run[g];
                if (run[g] && !enable_q[g]) begin
                    y1[g] <= 18'(signed'(phase[g]));
                    y2[g] <= 18'(signed'(coef_a));
                end else if (tick && run[g]) begin
                    y2[g] <= y1[g];
                    y1[g] <= next_y;
                end
            end
        end

        // output is oscillator state, linear in amplitude
        assign tone_out[g] = 16'(y1[g] >>> 2);

        // single counter alternates active and inactive
        // compare is >= so a shortened length cannot strand the count
        always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
                cad_count[g] <= RESET_VALUE;
                in_active[g] <= 1'b1;
                ending[g]    <= 1'b0;
            end else if (!run[g] && !(ta_en && ti_en)) begin
                cad_count[g] <= RESET_VALUE;
                in_active[g] <= 1'b1;
                ending[g]    <= 1'b0;
            end else if (tick && ta_en) begin
                if (in_active[g]) begin
                    // hold burst until a zero crossing
                    if (ending[g] || cad_count[g] >= active_len[g]) begin
                        if (!zero_en || zc) begin
                            cad_count[g] <= RESET_VALUE;
                            in_active[g] <= 1'b0;
                            ending[g]    <= 1'b0;
                        end else begin
                            ending[g] <= 1'b1;
                        end
                    end else begin
                        cad_count[g] <= cad_count[g] + 16'h0001;
                    end
                end else if (ti_en) begin
                    if (cad_count[g] >= inactive_len[g]) begin
                        cad_count[g] <= RESET_VALUE;
                        in_active[g] <= 1'b1;
                    end else begin
                        cad_count[g] <= cad_count[g] + 16'h0001;
                    end
                end
            end
        end

        assign expire[2*g]   = tick && ta_en && in_active[g] && run[g]
                               && (ending[g] || cad_count[g] >= active_len[g]) && (!zero_en || zc);
        assign expire[2*g+1] = tick && ta_en && ti_en && !in_active[g]
                               && cad_count[g] >= inactive_len[g];
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            control <= RESET_VALUE;
        end else begin
            for (int g = 0; g < 2; g++) begin
                if (ctl_wr) begin
                    control[8*g +: 8] <= reg_wdata[8*g +: 8];
                end else if (expire[2*g]) begin
                    control[8*g + CTL_OUT_EN] <= 1'b0;
                end else if (expire[2*g+1]) begin
                    control[8*g + CTL_OUT_EN] <= 1'b1;
                end
                control[8*g + CTL_PRESENT] <= run[g];
            end
        end
    end

    // sticky status, set beats read-clear
    // an expiry meeting the clearing read stays pending, never lost
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status <= 4'h0;
        end else begin
            irq_status <= ((reg_read && reg_addr == REG_IRQ_VECTOR) ? 4'h0 : irq_status) | expire;
        end
    end
    assign irq = |(irq_status & irq_mask);

    // route each tone to one path
    // two tones on one path add without saturation; keep amplitudes modest
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_tone <= 16'sh0000;
            tx_tone <= 16'sh0000;
        end else begin
            rx_tone <= (run[0] && !control[CTL_PATH] ? tone_out[0] : 16'sh0000)
                     + (run[1] && !control[8 + CTL_PATH] ? tone_out[1] : 16'sh0000);
            tx_tone <= (run[0] && control[CTL_PATH] ? tone_out[0] : 16'sh0000)
                     + (run[1] && control[8 + CTL_PATH] ? tone_out[1] : 16'sh0000);
        end
    end

    // checks watch generator 1 unless the label names generator 2; a_route_rx watches generator 2, status, irq and silence checks both
    a_status_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
        (|irq_status && !(reg_read && reg_addr == REG_IRQ_VECTOR)) |=> |irq_status)
        else $error("status bit lost without read");

    a_irq_level: assert property (@(posedge core_clk) disable iff (!reset_n)
        irq == |(irq_status & irq_mask))
        else $error("irq level mismatch");

    a_expire_sets: assert property (@(posedge core_clk) disable iff (!reset_n)
        expire[0] |=> irq_status[0])
        else $error("active expiry not recorded");

    a_inactive_sets: assert property (@(posedge core_clk) disable iff (!reset_n)
        expire[1] |=> irq_status[1])
        else $error("inactive expiry not recorded");

    a_gen2_sets: assert property (@(posedge core_clk) disable iff (!reset_n)
        expire[3] |=> irq_status[3])
        else $error("generator 2 inactive expiry not recorded");

    a_read_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
        (reg_read && reg_addr == REG_IRQ_VECTOR && expire == 4'h0) |=> irq_status == 4'h0)
        else $error("status not cleared by read");

    a_active_off: assert property (@(posedge core_clk) disable iff (!reset_n)
        (expire[0] && !ctl_wr) |=> !control[CTL_OUT_EN])
        else $error("enable not cleared at expiry");

    a_inactive_on: assert property (@(posedge core_clk) disable iff (!reset_n)
        (expire[1] && !ctl_wr) |=> control[CTL_OUT_EN])
        else $error("enable not set at inactive expiry");

    a_gen2_off: assert property (@(posedge core_clk) disable iff (!reset_n)
        (expire[2] && !ctl_wr) |=> !control[8 + CTL_OUT_EN])
        else $error("generator 2 enable not cleared at expiry");

    a_gen2_on: assert property (@(posedge core_clk) disable iff (!reset_n)
        (expire[3] && !ctl_wr) |=> control[8 + CTL_OUT_EN])
        else $error("generator 2 enable not set at inactive expiry");

    a_direct_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!control[CTL_TA_EN] && !control[CTL_TI_EN] && !ctl_wr) |=> $stable(control[CTL_OUT_EN]))
        else $error("enable moved without timers");

    a_one_shot_stop: assert property (@(posedge core_clk) disable iff (!reset_n)
        (expire[0] && !control[CTL_TI_EN] && !ctl_wr) |=> (!run[0] && cad_count[0] == RESET_VALUE))
        else $error("one-shot did not stop");

    a_count_step: assert property (@(posedge core_clk) disable iff (!reset_n)
        (tick && control[CTL_TA_EN] && run[0] && in_active[0] && !ending[0]
         && cad_count[0] < active_len[0]) |=> cad_count[0] == $past(cad_count[0]) + 16'h0001)
        else $error("cadence count did not advance");

    a_zero_end: assert property (@(posedge core_clk) disable iff (!reset_n)
        (expire[0] && control[CTL_ZERO]) |-> gen_tone[0].zc)
        else $error("burst ended off a zero crossing");

    a_phase_load: assert property (@(posedge core_clk) disable iff (!reset_n)
        (run[0] && !enable_q[0]) |=> y1[0] == 18'($past(signed'(phase[0]))))
        else $error("phase not reloaded");

    a_tick_period: assert property (@(posedge core_clk) disable iff (!reset_n)
        tick |=> !tick)
        else $error("tick too frequent");

    a_silent_off: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!run[0] && !run[1]) |=> (rx_tone == 16'sh0000 && tx_tone == 16'sh0000))
        else $error("tone while disabled");

    a_present_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
        1'b1 |=> control[CTL_PRESENT] == $past(run[0]))
        else $error("signal present flag stale");

    a_route_tx: assert property (@(posedge core_clk) disable iff (!reset_n)
        (run[0] && !run[1] && control[CTL_PATH]) |=> rx_tone == 16'sh0000)
        else $error("transmit tone leaked to receive");

    a_route_rx: assert property (@(posedge core_clk) disable iff (!reset_n)
        (run[1] && !run[0] && !control[8 + CTL_PATH]) |=> tx_tone == 16'sh0000)
        else $error("receive tone leaked to transmit");

    c_zero_hold: cover property (@(posedge core_clk) disable iff (!reset_n) ending[0]);
    c_burst_end: cover property (@(posedge core_clk) disable iff (!reset_n) expire[0]);
    c_burst_restart: cover property (@(posedge core_clk) disable iff (!reset_n) expire[1]);
    c_gen2_irq: cover property (@(posedge core_clk) disable iff (!reset_n) irq && irq_status[2]);
endmodule

// [tone_pkg.sv]
package tone_pkg;
    // register offsets (word index on the plain port)
    localparam logic [4:0] REG_T1_FREQ      = 5'h00;
    localparam logic [4:0] REG_T1_AMP       = 5'h01;
    localparam logic [4:0] REG_T1_PHASE     = 5'h02;
    localparam logic [4:0] REG_T1_ACTIVE    = 5'h03;
    localparam logic [4:0] REG_T1_INACTIVE  = 5'h04;
    localparam logic [4:0] REG_T2_FREQ      = 5'h05;
    localparam logic [4:0] REG_T2_AMP       = 5'h06;
    localparam logic [4:0] REG_T2_PHASE     = 5'h07;
    localparam logic [4:0] REG_T2_ACTIVE    = 5'h08;
    localparam logic [4:0] REG_T2_INACTIVE  = 5'h09;
    localparam logic [4:0] REG_OSC_CONTROL  = 5'h0A;
    localparam logic [4:0] REG_OSC_MODE     = 5'h0B;
    localparam logic [4:0] REG_IRQ_VECTOR   = 5'h0C;
    localparam logic [4:0] REG_IRQ_ENABLE   = 5'h0D;
    localparam logic [4:0] REG_FSK_SPACE_F  = 5'h0E;
    localparam logic [4:0] REG_FSK_MARK_F   = 5'h0F;
    localparam logic [4:0] REG_FSK_SPACE_A  = 5'h10;
    localparam logic [4:0] REG_FSK_MARK_A   = 5'h11;
    // control register fields, per generator byte: gen n at bit 8*n
    localparam int CTL_OUT_EN   = 0;
    localparam int CTL_TI_EN    = 1;
    localparam int CTL_TA_EN    = 2;
    localparam int CTL_PRESENT  = 3;
    localparam int CTL_PATH     = 4;
    localparam int CTL_ZERO     = 5;
    // mode register fields
    localparam int MODE_T1_FSK  = 0;
    localparam int MODE_FSK_SS  = 1;
    // irq bits: gen n active at 2n, inactive at 2n+1
    localparam logic [15:0] RESET_VALUE = 16'h0000;
    localparam int CLK_HZ        = 25_000_000;
    localparam int SAMPLE_HZ     = 8_000;
    localparam int FSK_HZ        = 24_000;
    localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
    localparam int FSK_CYCLES    = CLK_HZ / FSK_HZ;
    localparam int FREQ_SHIFT    = 14;
endpackage

// [tb.sv]
module tb
    import tone_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic               core_clk  = 1'b0;
    logic               reset_n   = 1'b0;
    logic        [4:0]  reg_addr  = 5'h00;
    logic        [15:0] reg_wdata = 16'h0000;
    logic               reg_write = 1'b0;
    logic               reg_read  = 1'b0;
    logic        [15:0] reg_rdata;
    logic               irq;
    logic signed [15:0] rx_tone;
    logic signed [15:0] tx_tone;
    logic               sample_strobe;
    int                 mismatches = 0;
    int                 n_checks   = 0;
    int                 seed       = 32'h695B7D54;
    int                 cnt;
    logic               rx_seen;
    logic               tx_seen;
    logic        [15:0] rd_val;
    logic        [15:0] expv [0:17];

    tone_generator i_dut (
        .core_clk      (core_clk),
        .reset_n       (reset_n),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_write     (reg_write),
        .reg_read      (reg_read),
        .reg_rdata     (reg_rdata),
        .irq           (irq),
        .rx_tone       (rx_tone),
        .tx_tone       (tx_tone),
        .sample_strobe (sample_strobe)
    );

    always #20 core_clk = ~core_clk;

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        mismatches++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_checks++;
        if (got !== exp) fail($sformatf("%s got %h expected %h", msg, got, exp));
    endtask

    task automatic chk_in(input int got, input int lo, input int hi, input string msg);
        n_checks++;
        if (got < lo || got > hi) fail($sformatf("%s got %0d, window %0d..%0d", msg, got, lo, hi));
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        @(negedge core_clk);
        rd_val = reg_rdata;
    endtask

    // sampled mid-cycle so registered outputs have settled
    task automatic step();
        @(negedge core_clk);
        if (rx_tone !== 16'sh0000) rx_seen = 1'b1;
        if (tx_tone !== 16'sh0000) tx_seen = 1'b1;
        if (sample_strobe === 1'b1) cnt++;
    endtask

    task automatic watch(input int n);
        rx_seen = 1'b0;
        tx_seen = 1'b0;
        cnt = 0;
        repeat (n * SAMPLE_CYCLES) step();
    endtask

    task automatic seen(input logic [15:0] exp, input string msg);
        chk16({14'h0000, rx_seen, tx_seen}, exp, msg);
    endtask

    task automatic wait_irq();
        int k;
        k = 0;
        rx_seen = 1'b0;
        tx_seen = 1'b0;
        cnt = 0;
        while (irq !== 1'b1) begin
            step();
            k++;
            if (k > 8 * SAMPLE_CYCLES) begin
                fail("irq never rose");
                close_out();
            end
        end
    endtask

    task automatic gap(output int n);
        int k;
        k = 0;
        n = 0;
        cnt = 0;
        while (cnt < 2 && k < 8000) begin
            step();
            k++;
            if (cnt == 1) n++;
        end
        if (cnt < 2) fail("sample tick missing");
    endtask

    initial begin
        int g;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        for (int a = 0; a < 18; a++) begin
            rd(5'(a));
            chk16(rd_val, RESET_VALUE, "reset value");
        end
        // control, mode and irq registers left out: random bits would start tones
        for (int a = 0; a < 18; a++) begin
            expv[a] = 16'($random(seed));
            if (a < 10 || a > 13) wr(5'(a), expv[a]);
        end
        wr(5'h1F, 16'($random(seed)));
        for (int a = 0; a < 18; a++) begin
            if (a < 10 || a > 13) begin
                rd(5'(a));
                chk16(rd_val, expv[a], "readback");
            end
        end
        rd(5'h1F);
        chk16(rd_val, 16'h0000, "unmapped read");
        gap(g);
        chk_in(g, SAMPLE_CYCLES - 1, SAMPLE_CYCLES + 1, "sample period");
        // fsk rate needs generator 1 running; zero space amplitude keeps it silent
        wr(REG_T1_PHASE, 16'h0000);
        wr(REG_FSK_SPACE_A, 16'h0000);
        wr(REG_FSK_MARK_A, 16'h0590);
        wr(REG_OSC_MODE, 16'h0001);
        wr(REG_OSC_CONTROL, 16'h0001);
        gap(g);
        gap(g);
        chk_in(g, FSK_CYCLES - 1, FSK_CYCLES + 1, "fsk sample period");
        watch(2);
        seen(16'h0000, "space coefficients silent");
        wr(REG_OSC_CONTROL, 16'h0000);
        wr(REG_OSC_MODE, 16'h0003);
        wr(REG_OSC_CONTROL, 16'h0001);
        watch(2);
        seen(16'h0002, "mark coefficients drive tone");
        wr(REG_OSC_CONTROL, 16'h0000);
        wr(REG_OSC_MODE, 16'h0000);
        wr(REG_T1_FREQ, 16'h3233);
        wr(REG_T1_AMP, 16'h0590);
        wr(REG_T1_PHASE, 16'h0000);
        wr(REG_OSC_CONTROL, 16'h0011);
        watch(2);
        seen(16'h0001, "direct enable on tx path");
        wr(REG_OSC_CONTROL, 16'h0001);
        watch(1);
        watch(1);
        seen(16'h0002, "direct enable on rx path");
        rd(REG_IRQ_VECTOR);
        chk16(rd_val, 16'h0000, "no timer status in direct mode");
        wr(REG_OSC_CONTROL, 16'h0000);
        wr(REG_T1_ACTIVE, 16'h0002);
        wr(REG_T1_INACTIVE, 16'h0003);
        wr(REG_IRQ_ENABLE, 16'h0003);
        rd(REG_IRQ_VECTOR);
        wr(REG_OSC_CONTROL, 16'h0007);
        wait_irq();
        chk_in(cnt, 2, 4, "active ticks");
        seen(16'h0002, "tone during active period");
        rd(REG_IRQ_VECTOR);
        chk16(rd_val, 16'h0001, "active expiry status");
        chk16({15'h0000, irq}, 16'h0000, "irq after read clear");
        watch(1);
        watch(2);
        seen(16'h0000, "silence in inactive period");
        wait_irq();
        chk_in(cnt, 0, 2, "inactive ticks");
        rd(REG_IRQ_VECTOR);
        chk16(rd_val, 16'h0002, "inactive expiry status");
        wr(REG_OSC_CONTROL, 16'h0000);
        wr(REG_T2_FREQ, 16'h1FE2);
        wr(REG_T2_AMP, 16'h0942);
        wr(REG_T2_PHASE, 16'h0000);
        wr(REG_T2_ACTIVE, 16'h0001);
        wr(REG_T2_INACTIVE, 16'h0001);
        wr(REG_IRQ_ENABLE, 16'h0000);
        rd(REG_IRQ_VECTOR);
        // no ringer in this bench, generator 2 may run
        wr(REG_OSC_CONTROL, 16'h1700);
        watch(5);
        seen(16'h0001, "second tone on tx only");
        chk16({15'h0000, irq}, 16'h0000, "masked status keeps irq low");
        rd(REG_IRQ_VECTOR);
        chk16(rd_val, 16'h000C, "second tone status bits");
        wr(REG_IRQ_ENABLE, 16'h000C);
        wait_irq();
        wr(REG_OSC_CONTROL, 16'h0000);
        rd(REG_IRQ_VECTOR);
        watch(1);
        watch(2);
        seen(16'h0000, "cadence stopped");
        rd(REG_IRQ_VECTOR);
        chk16(rd_val, 16'h0000, "timers idle after stop");
        wr(REG_IRQ_ENABLE, 16'h0001);
        wr(REG_OSC_CONTROL, 16'h0005);
        wait_irq();
        chk_in(cnt, 2, 4, "one-shot length");
        seen(16'h0002, "one-shot burst");
        watch(1);
        watch(3);
        seen(16'h0000, "silence after one-shot");
        rd(REG_IRQ_VECTOR);
        chk16(rd_val, 16'h0001, "one-shot status");
        wr(REG_OSC_CONTROL, 16'h0025);
        wait_irq();
        chk_in(cnt, 2, 9, "zero-cross burst length");
        rd(REG_IRQ_VECTOR);
        chk16(rd_val, 16'h0001, "zero-cross expiry status");
        close_out();
    end
endmodule
